// ---- verilog/uart_lsr_defs.svh ----
// Purpose: constants for the line status flag block
// Assumes: included by bare name from design files
// Notes: bit positions index the 8-bit line status word
`ifndef UART_LSR_DEFS_SVH
`define UART_LSR_DEFS_SVH

// line status bit positions
`define LS_DATA_READY_BIT 0
`define LS_OVERRUN_BIT 1
`define LS_PARITY_BIT 2
`define LS_FRAMING_BIT 3
`define LS_BREAK_BIT 4
`define LS_HOLD_EMPTY_BIT 5
`define LS_TX_EMPTY_BIT 6
`define LS_FIFO_ERR_BIT 7

// reset value: both transmit empties set, no errors, no data
`define LS_RESET_VALUE 8'h60

// buffering
`define LS_FIFO_DEPTH 8
`define LS_CHAR_WIDTH 8

// timing: bit time and clock period in ns
`define LS_CLK_PERIOD_NS 25
`define LS_BIT_TIME_NS 400
`define LS_CYCLES_PER_BIT (`LS_BIT_TIME_NS / `LS_CLK_PERIOD_NS)

// default frame length in bit times (start, 8 data, 1 stop)
`define LS_FRAME_BITS_DEFAULT 4'hA

`endif

// ---- verilog/uart_lsr_pkg.sv ----
// Purpose: types shared by the line status flag block
// Assumes: nothing beyond the defs header
// Notes: structs carry receive characters and the status word
`default_nettype none
package uart_lsr_pkg;

   // character as stored in the receive fifo
   typedef struct packed {
      logic brk;
      logic framing;
      logic parity;
      logic [7:0] data;
   } rx_char_t;

   // character handed over by the receive shifter
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic parity_bad;
      logic [1:0] stop_bits;
   } rx_word_t;

   // line status word, bit 7 first
   typedef struct packed {
      logic fifo_error_summary;
      logic transmitter_empty;
      logic holding_register_empty;
      logic break_flag;
      logic framing_error_flag;
      logic parity_error_flag;
      logic overrun_flag;
      logic receive_data_ready;
   } line_status_t;

   // break detector states
   typedef enum logic [1:0] {
      BRK_IDLE,
      BRK_COUNT,
      BRK_HELD
   } brk_state_t;

endpackage
`default_nettype wire

// ---- verilog/char_fifo.sv ----
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, DEPTH a power of two
// Notes: head word is read straight from the storage flops
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // handshakes
   assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_reg[rd_ptr_reg];

   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end

   // never overfilled, never underflowed
   a_fifo_bounds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      count_reg <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ---- verilog/break_detect.sv ----
// Purpose: flags a break once per low stretch of the receive line that spans frame_bits_i bit ticks
// Assumes: bit_tick_i is a one-cycle pulse per bit time
// Notes: rearms only after the line returns high
`timescale 1ns/1ps
`default_nettype none
module break_detect (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // line and timing
   input wire logic rx_i,
   input wire logic bit_tick_i,
   input wire logic [3:0] frame_bits_i,
   // result
   output logic break_o
);
   import uart_lsr_pkg::*;

   brk_state_t state_reg;
   logic [3:0] low_cnt_reg;

   // low-time counter and state
   // one break per condition
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= BRK_IDLE;
         low_cnt_reg <= 4'h0;
         break_o <= 1'b0;
      end else begin
         break_o <= 1'b0;
         unique case (state_reg)
            BRK_IDLE: begin
               low_cnt_reg <= 4'h0;
               if (!rx_i) state_reg <= BRK_COUNT;
            end
            BRK_COUNT: begin
               if (rx_i) begin
                  state_reg <= BRK_IDLE;
               end else if (bit_tick_i) begin
                  low_cnt_reg <= low_cnt_reg + 4'h1;
                  if (low_cnt_reg + 4'h1 >= frame_bits_i) begin
                     break_o <= 1'b1;
                     state_reg <= BRK_HELD;
                  end
               end
            end
            BRK_HELD: begin
               if (rx_i) state_reg <= BRK_IDLE;
            end
         endcase
      end
   end

   a_break_line_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      break_o |-> $past(!rx_i)) else $error("break with line high");
   a_break_only_once: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      break_o |=> !break_o [*8]) else $error("break reported twice");
endmodule
`default_nettype wire

// ---- verilog/uart_line_status.sv ----
// Purpose: line status flags of one serial channel, with rx and tx fifos
// Assumes: receive shifter and transmit shifter sit outside this block
// Notes: line_status_o is a snapshot register updated every cycle
`timescale 1ns/1ps
`default_nettype none
`include "uart_lsr_defs.svh"

// Function
// - error summary set while errors buffered
// - status read clears error summary
// - non-fifo: both holders empty sets empty
// - any held character clears transmitter empty
// - fifo mode: fifo and shifter empty
// - non-fifo: character moved to shifter sets hold-empty
// - host write clears hold-empty same cycle
// - hold-empty with enable raises interrupt
// - fifo mode: hold-empty follows fifo emptiness
// - line low one frame sets break
// - one break character per break
// - bad stop bit sets framing error
// - framing error belongs to head character
// - error flags zero after reset
// - parity error belongs to head character
// - full fifo on arrival flags overrun
// - data ready while characters wait
module uart_line_status #(
   parameter int DEPTH = `LS_FIFO_DEPTH,
   parameter int CYCLES_PER_BIT = `LS_CYCLES_PER_BIT
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // configuration
   input wire logic fifo_mode_i,
   input wire logic thr_int_enable_i,
   input wire logic two_stop_i,
   input wire logic [3:0] frame_bits_i,
   // receive line and shifter
   input wire logic rx_i,
   input wire uart_lsr_pkg::rx_word_t rx_word_i,
   // receive data to host
   input wire logic rx_pop_i,
   output logic [7:0] rx_data_o,
   // host writes to the transmit holding register
   input wire logic thr_write_i,
   input wire logic [7:0] thr_data_i,
   output logic thr_ready_o,
   // transmit shift register
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tsr_take_i,
   input wire logic tsr_busy_i,
   // line status read and interrupt
   input wire logic lsr_read_i,
   output var uart_lsr_pkg::line_status_t line_status_o,
   output logic thr_irq_o
);
   import uart_lsr_pkg::*;

   localparam int CW = $clog2(CYCLES_PER_BIT);
   localparam int EW = $clog2(DEPTH + 1);

   logic [CW:0] div_reg;
   logic bit_tick;
   logic break_pulse;
   rx_char_t rx_in;
   rx_char_t rx_head;
   logic rx_complete;
   logic rx_push_ready;
   logic rx_fifo_ready;
   logic rx_valid;
   logic rx_pop;
   logic rx_push;
   logic push_err;
   logic pop_err;
   logic [EW-1:0] err_cnt_reg;
   logic fe_sum_reg;
   logic overrun_reg;
   logic head_ack_reg;
   logic tx_fifo_ready;
   logic tx_empty;
   logic thr_accept;
   logic hre_live;
   logic temt_live;
   line_status_t status_live;

   // bit-rate enable from the system clock
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_reg <= '0;
      end else if (div_reg == (CW+1)'(CYCLES_PER_BIT - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end
   assign bit_tick = (div_reg == '0);

   // break detection on the raw line
   break_detect u_break (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .rx_i(rx_i),
      .bit_tick_i(bit_tick),
      .frame_bits_i(frame_bits_i),
      .break_o(break_pulse)
   );

   // build the stored character; a break enters as a zero character
   always_comb begin
      rx_in.brk = break_pulse;
      rx_in.data = break_pulse ? 8'h00 : rx_word_i.data;
      rx_in.parity = !break_pulse && rx_word_i.parity_bad;
      rx_in.framing = break_pulse ||
         !rx_word_i.stop_bits[0] || (two_stop_i && !rx_word_i.stop_bits[1]);
   end
   assign rx_complete = rx_word_i.valid || break_pulse;

   // one-character holder outside fifo mode
   assign rx_push_ready = fifo_mode_i ? rx_fifo_ready : !rx_valid;
   assign rx_push = rx_complete && rx_push_ready;
   assign rx_pop = rx_valid && rx_pop_i;

   char_fifo #(
      .WIDTH($bits(rx_char_t)),
      .DEPTH(DEPTH)
   ) u_rx_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(rx_complete && rx_push_ready),
      .in_ready_o(rx_fifo_ready),
      .in_data_i(rx_in),
      .out_valid_o(rx_valid),
      .out_ready_i(rx_pop_i),
      .out_data_o(rx_head)
   );
   assign rx_data_o = rx_head.data;

   // count of erroneous characters held in the receive fifo
   assign push_err = rx_push && (rx_in.brk || rx_in.framing || rx_in.parity);
   assign pop_err = rx_pop && (rx_head.brk || rx_head.framing || rx_head.parity);
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         err_cnt_reg <= '0;
      end else if (push_err && !pop_err) begin
         err_cnt_reg <= err_cnt_reg + 1'b1;
      end else if (pop_err && !push_err) begin
         err_cnt_reg <= err_cnt_reg - 1'b1;
      end
   end

   // error summary: arrival sets, read or draining clears, set wins
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fe_sum_reg <= 1'b0;
      end else if (push_err) begin
         fe_sum_reg <= 1'b1;
      end else if (lsr_read_i || err_cnt_reg == '0) begin
         fe_sum_reg <= 1'b0;
      end
   end

   // overrun: character lost, fifo left intact
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         overrun_reg <= 1'b0;
      end else if (rx_complete && !rx_push_ready) begin
         overrun_reg <= 1'b1;
      end else if (lsr_read_i) begin
         overrun_reg <= 1'b0;
      end
   end

   // head flags are hidden once read, until the head changes
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         head_ack_reg <= 1'b0;
      end else if (rx_pop) begin
         head_ack_reg <= 1'b0;
      end else if (lsr_read_i && rx_valid) begin
         head_ack_reg <= 1'b1;
      end
   end

   // transmit holding register, or fifo in fifo mode
   assign thr_ready_o = fifo_mode_i ? tx_fifo_ready : tx_empty;
   assign thr_accept = thr_write_i && thr_ready_o;

   char_fifo #(
      .WIDTH(`LS_CHAR_WIDTH),
      .DEPTH(DEPTH)
   ) u_tx_fifo (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(thr_write_i && thr_ready_o),
      .in_ready_o(tx_fifo_ready),
      .in_data_i(thr_data_i),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tsr_take_i),
      .out_data_o(tx_data_o)
   );
   assign tx_empty = !tx_valid_o;

   assign hre_live = tx_empty && !thr_accept;
   assign temt_live = hre_live && !tsr_busy_i;
   assign thr_irq_o = hre_live && thr_int_enable_i;

   // live status word
   always_comb begin
      status_live.fifo_error_summary = fe_sum_reg;
      status_live.transmitter_empty = temt_live;
      status_live.holding_register_empty = hre_live;
      status_live.break_flag = rx_valid && rx_head.brk && !head_ack_reg;
      status_live.framing_error_flag = rx_valid && rx_head.framing && !head_ack_reg;
      status_live.parity_error_flag = rx_valid && rx_head.parity && !head_ack_reg;
      status_live.overrun_flag = overrun_reg;
      status_live.receive_data_ready = rx_valid;
   end

   // registered snapshot presented to the host
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_status_o <= `LS_RESET_VALUE;
      end else begin
         line_status_o <= status_live;
      end
   end

   // all checks below run on the system clock, quiet during reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // a single-entry character handed to the shifter, no write behind it
   sequence s_char_moves;
      !fifo_mode_i && tx_valid_o && tsr_take_i && !thr_write_i;
   endsequence
   // an errored character stored, with no status read just after
   sequence s_error_arrives;
      push_err ##1 !lsr_read_i;
   endsequence

   // error summary: set by errored arrivals, cleared by a status read
   a_err_sum_set: assert property (s_error_arrives |->
      fe_sum_reg ##1 line_status_o.fifo_error_summary)
      else $error("summary not set");
   a_err_sum_read: assert property (lsr_read_i && !push_err |=>
      !fe_sum_reg ##1 !line_status_o.fifo_error_summary)
      else $error("summary survives read");

   // transmitter empty follows both holders
   a_temt_set: assert property (tx_empty && !tsr_busy_i && !thr_write_i |=>
      line_status_o.transmitter_empty)
      else $error("empty not shown");
   a_temt_busy: assert property (tsr_busy_i |=>
      !line_status_o.transmitter_empty)
      else $error("empty while shifting");
   a_temt_fifo: assert property (fifo_mode_i && tx_valid_o |=>
      !line_status_o.transmitter_empty)
      else $error("empty with fifo data");

   // holding-register empty and its interrupt
   a_hre_move: assert property (s_char_moves |=>
      hre_live || thr_write_i)
      else $error("hold empty not set");
   a_hre_write: assert property (thr_accept |->
      !hre_live ##1 !line_status_o.holding_register_empty)
      else $error("hold empty after write");
   a_hre_irq: assert property (thr_int_enable_i && !tx_valid_o && !thr_write_i |->
      thr_irq_o)
      else $error("missing interrupt");
   a_hre_fifo: assert property (fifo_mode_i && thr_accept |=>
      !hre_live)
      else $error("fifo write kept empty");

   // receive side: stop check, head flags, break storage, overrun
   a_frame_stop: assert property (
      rx_word_i.valid && !rx_word_i.stop_bits[0] |-> rx_in.framing)
      else $error("missing stop not flagged");
   a_head_framing: assert property (
      rx_valid && rx_head.framing && !head_ack_reg |=> line_status_o.framing_error_flag)
      else $error("head framing lost");
   a_head_parity: assert property (
      rx_valid && rx_head.parity && !head_ack_reg |=> line_status_o.parity_error_flag)
      else $error("head parity lost");
   a_break_stored: assert property (break_pulse && rx_push_ready |=> rx_valid)
      else $error("break character not stored");
   a_overrun_set: assert property (
      rx_complete && !rx_push_ready && !rx_pop_i |=> overrun_reg && $stable(rx_valid))
      else $error("overrun missed");
   a_rx_ready: assert property (rx_valid |=> line_status_o.receive_data_ready)
      else $error("data ready missing");
   a_flags_read: assert property (
      lsr_read_i && rx_valid && !rx_pop |=>
      !status_live.parity_error_flag && !status_live.break_flag)
      else $error("flags survive read");
endmodule
`default_nettype wire

// ---- bench/tx_shifter_model.sv ----
// Purpose: transmit shift register model on the far side of the block
// Assumes: tx_valid_i stands until taken; inputs change 2 ns after the edge
// Notes: stall_i holds off taking; each character keeps busy high SHIFT cycles
`timescale 1ns/1ps
`default_nettype none
module tx_shifter_model #(
   parameter int SHIFT = 6
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // bench control
   input wire logic stall_i,
   // offer from the block
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   // answer to the block
   output logic tsr_take_o,
   output logic tsr_busy_o,
   // record of what left
   output logic [7:0] last_o,
   output int count_o
);
   int left;
   logic go;
   initial begin
      tsr_take_o = 1'b0;
      tsr_busy_o = 1'b0;
      last_o = 8'h00;
      count_o = 0;
      left = 0;
   end
   // capture and sample the offer on the edge, move outputs just after it
   always @(posedge clk_i) begin
      if (tsr_take_o) begin
         last_o = tx_data_i;
         count_o = count_o + 1;
      end
      go = tx_valid_i && !stall_i; // stall changes after the edge, so read it here
      #2;
      if (!reset_n_i) begin
         tsr_take_o <= 1'b0;
         tsr_busy_o <= 1'b0;
         left = 0;
      end else if (tsr_take_o) begin
         tsr_take_o <= 1'b0;
         tsr_busy_o <= 1'b1;
         left = SHIFT;
      end else if (left > 0) begin
         left = left - 1;
         if (left == 0) begin
            tsr_busy_o <= 1'b0;
         end
      end else if (go) begin
         tsr_take_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- bench/test_uart_line_status_flags.sv ----
// Purpose: self-checking bench for the line status flag block
// Assumes: bit time shortened to 2 cycles, frame of 10 bits
// Notes: status register lags live status by one cycle, so checks wait 2
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_status_flags;
   import uart_lsr_pkg::*;
   logic clk, reset_n, fifo_mode, irq_en, two_stop, rx, rx_pop, thr_write, lsr_read, stall;
   logic thr_ready, tx_valid, take, busy, irq;
   logic [7:0] thr_data, rx_data, tx_data, last;
   rx_word_t rx_word;
   line_status_t ls;
   int count, errors, cmp_count, n;
   uart_line_status #(.DEPTH(8), .CYCLES_PER_BIT(2)) dut (
      .clk_i(clk), .reset_n_i(reset_n), .fifo_mode_i(fifo_mode), .thr_int_enable_i(irq_en),
      .two_stop_i(two_stop), .frame_bits_i(4'hA), .rx_i(rx), .rx_word_i(rx_word),
      .rx_pop_i(rx_pop), .rx_data_o(rx_data), .thr_write_i(thr_write), .thr_data_i(thr_data),
      .thr_ready_o(thr_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
      .tsr_take_i(take), .tsr_busy_i(busy), .lsr_read_i(lsr_read),
      .line_status_o(ls), .thr_irq_o(irq));
   tx_shifter_model partner (
      .clk_i(clk), .reset_n_i(reset_n), .stall_i(stall), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tsr_take_o(take), .tsr_busy_o(busy), .last_o(last),
      .count_o(count));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic final_report();
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   // a used-up wait counts as a mismatch and ends the run
   task automatic guard();
      if (n >= 300) begin
         errors++;
         $display("[FAIL] %0t wait ran out", $time);
         final_report();
      end
   endtask
   task automatic write_thr(input logic [7:0] d);
      n = 0;
      while (thr_ready !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      guard();
      thr_write = 1'b1;
      thr_data = d;
      tick(1);
      thr_write = 1'b0;
      // let an edge pass so the next write starts cleanly
      tick(1);
   endtask
   task automatic rx_char(input logic [7:0] d, input logic p, input logic [1:0] s);
      rx_word = {1'b1, d, p, s};
      tick(1);
      rx_word.valid = 1'b0;
      // let an edge pass so the next character starts cleanly
      tick(1);
   endtask
   task automatic pop();
      rx_pop = 1'b1;
      tick(1);
      rx_pop = 1'b0;
      tick(2);
   endtask
   task automatic read_lsr();
      lsr_read = 1'b1;
      tick(1);
      lsr_read = 1'b0;
      tick(2);
   endtask
   task automatic wait_busy(input logic lvl);
      n = 0;
      while (busy !== lvl && n < 300) begin
         tick(1);
         n++;
      end
      guard();
      tick(2);
   endtask
   task automatic s_reset();
      check(ls, 8'h60);
      check(irq, 1'b0);
   endtask
   task automatic s_tx_char();
      irq_en = 1'b1;
      #1;
      check(irq, 1'b1);
      tick(1);
      thr_write = 1'b1;
      thr_data = 8'h5A;
      #1;
      check(irq, 1'b0);
      tick(1);
      thr_write = 1'b0;
      tick(2);
      check({ls.transmitter_empty, ls.holding_register_empty}, 8'h0);
      stall = 1'b0;
      wait_busy(1'b1);
      check({ls.transmitter_empty, ls.holding_register_empty}, 8'h1);
      wait_busy(1'b0);
      check(ls.transmitter_empty, 1'b1);
      check(last, 8'h5A);
   endtask
   task automatic s_tx_fifo();
      fifo_mode = 1'b1;
      stall = 1'b1;
      for (int i = 0; i < 8; i++) begin
         write_thr(8'hA0 + 8'(i));
      end
      tick(2);
      check(thr_ready, 1'b0);
      check({ls.transmitter_empty, ls.holding_register_empty}, 8'h0);
      // a write to the full fifo must be dropped
      thr_write = 1'b1;
      thr_data = 8'hFF;
      tick(1);
      thr_write = 1'b0;
      stall = 1'b0;
      n = 0;
      while (count != 9 && n < 300) begin
         tick(1);
         n++;
      end
      guard();
      wait_busy(1'b1);
      check({ls.transmitter_empty, ls.holding_register_empty}, 8'h1);
      wait_busy(1'b0);
      check(ls.transmitter_empty, 1'b1);
      check(last, 8'hA7);
      check(8'(count), 8'd9);
   endtask
   task automatic s_rx_errors();
      rx_char(8'h11, 1'b0, 2'b11);
      rx_char(8'h22, 1'b0, 2'b10);
      rx_char(8'h33, 1'b1, 2'b11);
      tick(2);
      check({ls.fifo_error_summary, ls.framing_error_flag, ls.parity_error_flag}, 8'h4);
      check(ls.receive_data_ready, 1'b1);
      check(rx_data, 8'h11);
      pop();
      check({ls.framing_error_flag, ls.parity_error_flag}, 8'h2);
      check(rx_data, 8'h22);
      pop();
      check({ls.framing_error_flag, ls.parity_error_flag}, 8'h1);
      read_lsr();
      check({ls.fifo_error_summary, ls.parity_error_flag}, 8'h0);
      pop();
      check(ls.receive_data_ready, 1'b0);
      two_stop = 1'b1;
      rx_char(8'h44, 1'b0, 2'b01);
      tick(2);
      check(ls.framing_error_flag, 1'b1);
      pop();
      two_stop = 1'b0;
   endtask
   task automatic s_overrun();
      for (int i = 0; i < 9; i++) begin
         rx_char(8'(i), 1'b0, 2'b11);
      end
      tick(2);
      check(ls.overrun_flag, 1'b1);
      for (int i = 0; i < 8; i++) begin
         check(rx_data, 8'(i));
         pop();
      end
      check(ls.receive_data_ready, 1'b0);
      read_lsr();
      check(ls.overrun_flag, 1'b0);
   endtask
   task automatic s_break();
      rx = 1'b0;
      tick(10);
      rx = 1'b1;
      tick(3);
      check(ls.receive_data_ready, 1'b0);
      rx = 1'b0;
      tick(70);
      rx = 1'b1;
      tick(3);
      check({ls.receive_data_ready, ls.break_flag, ls.fifo_error_summary}, 8'h7);
      check(rx_data, 8'h00);
      pop();
      check(ls.receive_data_ready, 1'b0);
   endtask
   // main sequence
   initial begin
      errors = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      {fifo_mode, irq_en, two_stop, rx_pop, thr_write, lsr_read} = 6'h00;
      rx = 1'b1;
      stall = 1'b1;
      thr_data = 8'h00;
      rx_word = '0;
      repeat (8) @(posedge clk);
      #2;
      reset_n = 1'b1;
      tick(1);
      s_reset();
      s_tx_char();
      s_tx_fifo();
      s_rx_errors();
      s_overrun();
      s_break();
      final_report();
   end
endmodule
`default_nettype wire
